// *** verilog/group_sel_pkg.sv ***
// package for the setting-bank selector: register map, field layout, reset values
// assumes a single 20 MHz clock and an AXI4-Lite register bus
package group_sel_pkg;
    localparam int ADDR_W = 8;
    localparam int BANKS = 4;
    localparam int PARAM_W = 16;
    localparam int PARAMS = 4;
    localparam int LOG_DEPTH = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_LOG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PARAM_IDX = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PARAM_DATA = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_ENABLES = 8'h1C;
    // ctrl fields
    localparam int CTRL_CFG_LSB = 0;
    localparam int CTRL_EDIT_LSB = 2;
    localparam int CTRL_EDIT_ACTIVE = 4;
    localparam int CTRL_HOLD_BRK = 5;
    localparam int CTRL_HOLD_OC = 6;
    localparam int CTRL_HOLD_OV = 7;
    localparam int CTRL_HOLD_UV = 8;
    localparam int CTRL_HOLD_UF = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] BANK_1 = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // element enables: one bit per class
    localparam int EN_OC = 0;
    localparam int EN_OV = 1;
    localparam int EN_UV = 2;
    localparam int EN_UF = 3;
    localparam logic [3:0] ENABLES_RESET = 4'hF;

    typedef struct packed {
        logic oc;
        logic ov;
        logic uv;
        logic uf;
    } pickup_s;

    typedef struct packed {
        logic [1:0] from_bank;
        logic [1:0] to_bank;
    } log_entry_s;
endpackage

// *** verilog/setpoint_group_selector.sv ***
// setting-bank selector: picks the active bank of four, holds changes, logs them
// assumes pickup, breaker and group inputs arrive from pins, asynchronous to aclk
//
// How it works
// - after reset bank 1 is active until something selects another
// - writing the configured group switches the bank; indicators follow
// - element parameters are read only from the active bank
// - an edit-bank field chooses the bank written, with a track-active choice
// - several group inputs asserted pick the highest numbered group
// - releasing inputs falls back to next highest asserted, else the configured bank
// - every bank change pushes an entry into the event log
// - breaker-open hold defers a change while the breaker reads open
// - deferred change applies once the breaker reads closed
// - overcurrent hold defers while an enabled overcurrent element is picked up
// - deferred change applies when the last overcurrent pickup resets
// - overvoltage hold defers while an enabled element is picked up
// - undervoltage hold defers while an enabled element is picked up
// - underfrequency hold defers while an enabled element is picked up
// - during any hold the indicators keep showing the previous bank
module setpoint_group_selector
    import group_sel_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] group_select_in,
    input wire logic breaker_closed_in,
    input wire pickup_s pickup_in,
    output logic [1:0] active_bank,
    output logic [3:0] bank_indicator,
    output logic [PARAMS*PARAM_W-1:0] active_params,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, a change counts once stages 2 and 3 agree
    localparam int SYNC_W = 8;
    logic [SYNC_W-1:0] sync1, sync2, sync3, pin_state;
    wire [SYNC_W-1:0] pins = {group_select_in, breaker_closed_in, pickup_in};

    always_ff @(posedge aclk) begin
        sync1 <= pins;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // stage 3 only filters; the held state updates when the late stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_state <= {SYNC_W{1'b0}};
        end else begin
            for (int i = 0; i < SYNC_W; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_state[i] <= sync3[i];
                end
            end
        end
    end

    wire [2:0] grp_in = pin_state[7:5];
    wire brk_closed = pin_state[4];
    pickup_s pu;
    assign pu = pin_state[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl;
    logic [3:0] enables;
    logic [3:0] irq_stat, irq_mask;
    logic [1:0] param_idx;
    logic [PARAM_W-1:0] bank_mem [BANKS][PARAMS];
    log_entry_s log_mem [LOG_DEPTH];
    logic [2:0] log_wr, log_rd;
    logic [3:0] log_count;

    wire [1:0] cfg_bank = ctrl[CTRL_CFG_LSB +: 2];
    wire edit_active = ctrl[CTRL_EDIT_ACTIVE];
    wire [1:0] edit_bank = edit_active ? active_bank : ctrl[CTRL_EDIT_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // bank request and hold
    // highest asserted group input wins, nothing asserted means the configured bank
    wire [1:0] input_bank = grp_in[2] ? 2'h3 :
                            grp_in[1] ? 2'h2 :
                            grp_in[0] ? 2'h1 : BANK_1;
    wire any_input = |grp_in;
    wire [1:0] req_bank = any_input ? input_bank : cfg_bank;

    wire hold_while_breaker_open = ctrl[CTRL_HOLD_BRK] && !brk_closed;
    wire hold_oc = ctrl[CTRL_HOLD_OC] && pu.oc && enables[EN_OC];
    wire hold_while_overvoltage_picked = ctrl[CTRL_HOLD_OV] && pu.ov && enables[EN_OV];
    wire hold_while_undervoltage_picked = ctrl[CTRL_HOLD_UV] && pu.uv && enables[EN_UV];
    wire hold_while_underfrequency_picked = ctrl[CTRL_HOLD_UF] && pu.uf && enables[EN_UF];
    wire hold_any = hold_while_breaker_open || hold_oc || hold_while_overvoltage_picked ||
                    hold_while_undervoltage_picked || hold_while_underfrequency_picked;
    // a held request is simply re-evaluated each cycle, so it applies when hold drops
    wire change = (req_bank != active_bank) && !hold_any;

    wire [3:0] next_indicator = 4'h1 << req_bank;

    // bank and indicator share one enable, so they can never show different groups
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_bank <= BANK_1;
        end else if (change) begin
            active_bank <= req_bank;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_indicator <= 4'h1;
        end else if (change) begin
            bank_indicator <= next_indicator;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parameter output from the active bank only
    logic [PARAMS*PARAM_W-1:0] next_params;
    always_comb begin
        next_params = '0;
        for (int p = 0; p < PARAMS; p++) begin
            next_params[p*PARAM_W +: PARAM_W] = bank_mem[active_bank][p];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_params <= '0;
        end else begin
            active_params <= next_params;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire [ADDR_W-1:0] wa = aw_take ? s_axi_awaddr : aw_addr;
    wire [31:0] wd = w_take ? s_axi_wdata : w_data;
    wire [3:0] ws = w_take ? s_axi_wstrb : w_strb;
    wire wr_go = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
    wire wr_ok = wa == OFF_CTRL || wa == OFF_IRQ_MASK || wa == OFF_PARAM_IDX ||
                 wa == OFF_PARAM_DATA || wa == OFF_ENABLES || wa == OFF_STATUS ||
                 wa == OFF_IRQ_STAT || wa == OFF_LOG;
    wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire [31:0] ctrl_new = (ctrl & ~wmask) | (wd & wmask);
    // a new address or data beat waits until the previous response is taken
    wire aw_open = !aw_held && !aw_take && !wr_go && !s_axi_bvalid;
    wire w_open = !w_held && !w_take && !wr_go && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= aw_open;
            s_axi_wready <= w_open;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else begin
                aw_held <= aw_held || aw_take;
                w_held <= w_held || w_take;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= !aw_held;
                s_axi_wready <= !w_held;
            end
        end
    end

    // write decodes, one strobe per register
    wire wr_ctrl = wr_go && wa == OFF_CTRL;
    wire wr_mask = wr_go && wa == OFF_IRQ_MASK && ws[0];
    wire wr_idx = wr_go && wa == OFF_PARAM_IDX && ws[0];
    wire wr_enables = wr_go && wa == OFF_ENABLES && ws[0];
    wire wr_param = wr_go && wa == OFF_PARAM_DATA;

    // only implemented control bits are kept, so reads never show stray ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= ctrl_new & 32'h0000_03FF;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= wd[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            param_idx <= '0;
        end else if (wr_idx) begin
            param_idx <= wd[1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enables <= ENABLES_RESET;
        end else if (wr_enables) begin
            enables <= wd[3:0];
        end
    end

    // bank storage has no reset: contents are software's to load
    always_ff @(posedge aclk) begin
        if (wr_param) begin
            bank_mem[edit_bank][param_idx] <= wd[PARAM_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire log_pop = rd_go && s_axi_araddr == OFF_LOG && log_count != 4'h0;
    wire stat_rd = rd_go && s_axi_araddr == OFF_IRQ_STAT;
    // status and log words built apart so the read mux stays a plain select
    wire [3:0] status_pins = pin_state[7:4];
    wire [31:0] status_word = {17'h0, log_count, status_pins, pu, hold_any, active_bank};
    wire [31:0] log_word = {log_count != 4'h0, 27'h0, log_mem[log_rd]};
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            OFF_CTRL: rd_val = ctrl;
            OFF_STATUS: rd_val = status_word;
            OFF_IRQ_STAT: rd_val = {28'h0, irq_stat};
            OFF_IRQ_MASK: rd_val = {28'h0, irq_mask};
            OFF_LOG: rd_val = log_word;
            OFF_PARAM_IDX: rd_val = {30'h0, param_idx};
            OFF_PARAM_DATA: rd_val = {16'h0, bank_mem[edit_bank][param_idx]};
            OFF_ENABLES: rd_val = {28'h0, enables};
            default: begin
                rd_val = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event log: ring of bank changes; oldest entry lost when full
    wire log_full = log_count == LOG_DEPTH[3:0];
    // a pop and a push in one cycle leave the count alone
    wire log_inc = change && !log_pop && !log_full;
    wire log_dec = log_pop && !change;
    wire log_adv = log_pop || (change && log_full);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            log_wr <= '0;
            log_rd <= '0;
            log_count <= '0;
        end else begin
            if (change) begin
                log_mem[log_wr] <= '{from_bank: active_bank, to_bank: req_bank};
                log_wr <= log_wr + 3'h1;
            end
            if (log_adv) begin
                log_rd <= log_rd + 3'h1;
            end
            if (log_inc) begin
                log_count <= log_count + 4'h1;
            end else if (log_dec) begin
                log_count <= log_count - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: bit0 bank change, bit1 change deferred, bit2 log overflow,
    // bit3 hold released; read clears, a same-cycle event wins
    logic hold_any_q;
    wire ev_change = change;
    wire ev_deferred = hold_any && req_bank != active_bank;
    wire ev_overflow = change && log_full;
    wire ev_released = hold_any_q && !hold_any;
    wire [3:0] ev = {ev_released, ev_overflow, ev_deferred, ev_change};
    wire [3:0] irq_pending = irq_stat & irq_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_any_q <= 1'b0;
        end else begin
            hold_any_q <= hold_any;
        end
    end

    // an event in the cycle of the clearing read survives it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (stat_rd ? 4'h0 : irq_stat) | ev;
        end
    end

    // registered for a clean pin; lags the status bits by one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |irq_pending;
        end
    end

endmodule

// *** sim/setpoint_group_selector_monitor.sv ***
// checker for the setting-bank selector: bank, indicator and bus handshakes
// assumes group_sel_pkg is compiled first; bound to the selector at the foot
module setpoint_group_selector_monitor
    import group_sel_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [2:0] group_select_in,
    input wire logic breaker_closed_in,
    input wire pickup_s pickup_in,
    input wire logic [1:0] active_bank,
    input wire logic [3:0] bank_indicator
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // with breaker closed and nothing picked up no hold can be active
    wire logic no_hold = breaker_closed_in && pickup_in == '0;
    ////////////////////////////////////////////////////////////////////////
    AST_RESET_BANK: assert property (disable iff (1'b0) !aresetn |=>
        active_bank == BANK_1 && bank_indicator == 4'h1)
        else $error("bank not reset to first bank");
    AST_IND_MATCH: assert property (bank_indicator == (4'h1 << active_bank))
        else $error("indicator differs from active bank");
    // 8 cycles cover pin synchroniser plus the bank register
    AST_PIN_GRP4: assert property ((group_select_in[2] && no_hold)[*8] |->
        active_bank == 2'h3)
        else $error("group 4 pin not selecting bank 4");
    AST_PIN_GRP3: assert property ((group_select_in[2:1] == 2'b01 && no_hold)[*8] |->
        active_bank == 2'h2)
        else $error("group 3 pin not selecting bank 3");
    AST_PIN_GRP2: assert property ((group_select_in == 3'b001 && no_hold)[*8] |->
        active_bank == 2'h1)
        else $error("group 2 pin not selecting bank 2");
    AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule
////////////////////////////////////////////////////////////////////////////
bind setpoint_group_selector setpoint_group_selector_monitor i_mon (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .group_select_in, .breaker_closed_in, .pickup_in, .active_bank, .bank_indicator
);

// *** sim/setpoint_group_selector_tb.sv ***
// bench for the setting-bank selector: config, pins, holds, params, log, irq
// assumes the package and the bound monitor are compiled before this file
module setpoint_group_selector_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import group_sel_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, breaker_closed_in;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, bank_indicator;
    logic [1:0] s_axi_bresp, s_axi_rresp, active_bank, r;
    logic [2:0] group_select_in;
    pickup_s pickup_in;
    logic [PARAMS*PARAM_W-1:0] active_params;
    int errors, checks;
    setpoint_group_selector i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .group_select_in, .breaker_closed_in, .pickup_in, .active_bank,
        .bank_indicator, .active_params, .irq);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hang();
        errors++;
        results();
    endtask
    // each bus task lets one edge pass first so no strobe is driven twice in a step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v,
                      input logic [1:0] er = RESP_OKAY);
        bit ta, tw, tb;
        ta = 0;
        tw = 0;
        tb = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !tb; n++) begin
            @(posedge aclk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
            s_axi_bready <= !tb;
        end
        if (!tb) hang();
        chk("bresp", 32'(r), 32'(er));
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        bit got;
        got = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            got = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
        if (!got) hang();
    endtask
    task automatic bank_is(input logic [1:0] e);
        for (int n = 0; n < 20 && active_bank !== e; n++) @(posedge aclk);
        chk("active_bank", 32'(active_bank), 32'(e));
        chk("bank_indicator", 32'(bank_indicator), 32'(4'h1 << e));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_config();
        rd(OFF_CTRL);
        chk("ctrl reset", d, CTRL_RESET);
        rd(OFF_ENABLES);
        chk("enables reset", d, 32'(ENABLES_RESET));
        wr(OFF_IRQ_MASK, 32'h1);
        for (int b = 1; b <= 4; b++) begin
            wr(OFF_CTRL, 32'(b % 4));
            bank_is(2'(b % 4));
        end
        chk("irq", 32'(irq), 32'h1);
        rd(OFF_IRQ_STAT);
        chk("irq_stat", d & 32'h1, 32'h1);
        repeat (3) @(posedge aclk);
        chk("irq cleared", 32'(irq), 32'h0);
        rd(OFF_LOG);
        chk("log entry", d & 32'h8000_000F, 32'h8000_0001);
        rd(8'h40);
        chk("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
        wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    endtask
    task automatic t_params();
        wr(OFF_CTRL, 32'h1 << CTRL_EDIT_ACTIVE);
        wr(OFF_PARAM_IDX, 32'h0);
        wr(OFF_PARAM_DATA, 32'h0000_A5A5);
        wr(OFF_CTRL, 32'h4);
        wr(OFF_PARAM_DATA, 32'h0000_5A5A);
        repeat (4) @(posedge aclk);
        chk("params bank1", 32'(active_params[15:0]), 32'h0000_A5A5);
        wr(OFF_CTRL, 32'h5);
        bank_is(2'h1);
        repeat (2) @(posedge aclk);
        chk("params bank2", 32'(active_params[15:0]), 32'h0000_5A5A);
    endtask
    task automatic t_pins();
        logic [2:0] pins [6] = '{3'h1, 3'h3, 3'h7, 3'h3, 3'h1, 3'h0};
        logic [1:0] exp [6] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h2};
        wr(OFF_CTRL, 32'h2);
        bank_is(2'h2);
        for (int i = 0; i < 6; i++) begin
            group_select_in <= pins[i];
            repeat (2) @(posedge aclk);
            bank_is(exp[i]);
        end
        wr(OFF_CTRL, 32'h0);
        bank_is(2'h0);
    endtask
    // k 0 breaker open, then oc, ov, uv, uf pickups
    task automatic t_hold();
        for (int k = 0; k < 5; k++) begin
            wr(OFF_CTRL, 32'h1 << (CTRL_HOLD_BRK + k));
            group_select_in <= 3'h1;
            bank_is(2'h1);
            if (k == 0) breaker_closed_in <= 1'b0;
            else pickup_in <= pickup_s'(4'h8 >> (k - 1));
            repeat (8) @(posedge aclk);
            group_select_in <= 3'h0;
            repeat (10) @(posedge aclk);
            bank_is(2'h1);
            breaker_closed_in <= 1'b1;
            pickup_in <= '0;
            bank_is(2'h0);
        end
        wr(OFF_ENABLES, 32'hE);
        wr(OFF_CTRL, 32'h1 << CTRL_HOLD_OC);
        group_select_in <= 3'h1;
        bank_is(2'h1);
        pickup_in <= pickup_s'(4'h8);
        repeat (8) @(posedge aclk);
        group_select_in <= 3'h0;
        bank_is(2'h0);
        pickup_in <= '0;
        rd(OFF_IRQ_STAT);
        chk("irq_stat hold events", d & 32'hE, 32'hE);
        rd(OFF_STATUS);
        chk("status bank and hold", d & 32'h7, 32'h0);
    endtask
    initial begin
        errors = 0;
        checks = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        group_select_in = '0;
        breaker_closed_in = 1'b1;
        pickup_in = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bank_is(2'h0);
        t_config();
        t_params();
        t_pins();
        t_hold();
        results();
    end
endmodule
